/* File: logic/link_sync_regs.svh */
// register offsets, field positions and codes for the link sync and test control block
// assumes a slave port decoder outside that delivers byte-wide register strobes
`ifndef LINK_SYNC_REGS_SVH
`define LINK_SYNC_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_LINK_SYNC_STATE 8'h3E
`define OFS_TEST_PATTERN 8'h7E
`define OFS_TEST_CHANNEL 8'h7F

// ****************************************
// sync state values and reset values
// ****************************************
`define SYNC_IDLE_OK 8'h00
`define SYNC_BUSY 8'h01
`define SYNC_IDLE_FAIL 8'h02
`define TEST_REG_RESET 8'h00

// ****************************************
// field positions and codes
// ****************************************
`define TEST_CODE_SINGLE 8'h63
`define TEST_CODE_SWEEP 8'h73
`define TEST_DIR_BIT 7
`define TEST_CH_MSB 6
`define FORCE_RECONFIG_BIT 4
`define INT_REMOTE_DONE_BIT 4
`define LINK_REG_COUNT 9

`endif

/* File: logic/link_sync_pkg.sv */
// types shared by the link sync controller and its sequencer
// assumes the constants header is compiled alongside
`default_nettype none
package link_sync_pkg;
    // sequencer states, binary codes written out
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SEND = 2'b01
    } seq_state_t;
endpackage
`default_nettype wire

/* File: logic/sync_xfer_if.sv */
// control and link signals between the controller and its sequencer
// assumes both ends run on the same clock
`default_nettype none
interface sync_xfer_if #(parameter int IDX_W = 4);
    logic start;             // one-cycle request to begin a transfer
    logic done;              // one-cycle pulse, all values delivered
    logic fail;              // one-cycle pulse, transfer aborted
    logic valid;             // a register value is being offered
    logic [IDX_W-1:0] index; // which link register is offered
    modport ctrl (output start, input done, input fail, input valid, input index);
    modport seq (input start, output done, output fail, output valid, output index);
endinterface
`default_nettype wire

/* File: logic/sync_sequencer.sv */
// walks the link register list and offers each value to the control channel
// assumes the radio side answers each offer with ack or fail, never both
`include "link_sync_regs.svh"
`default_nettype none
module sync_sequencer
    import link_sync_pkg::*;
#(
    parameter int NREG = `LINK_REG_COUNT,
    parameter int IDX_W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // controller side
    sync_xfer_if.seq xf,
    // radio answers
    input wire logic link_ack,
    input wire logic link_fail
);
    // ****************************************
    // state
    // ****************************************
    seq_state_t state_r; // walking or not
    logic [IDX_W-1:0] idx_r; // current register
    logic done_r; // delivered pulse
    logic fail_r; // abort pulse
    localparam logic [IDX_W-1:0] LAST = IDX_W'(NREG - 1);

    // sequence through the list; channel registers are not in it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= SEQ_IDLE;
            idx_r <= '0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            case (state_r)
                SEQ_IDLE: begin
                    if (xf.start) begin
                        state_r <= SEQ_SEND;
                        idx_r <= '0;
                    end
                end
                SEQ_SEND: begin
                    // fail wins over ack: one bad value spoils the set
                    if (link_fail) begin
                        state_r <= SEQ_IDLE;
                        fail_r <= 1'b1;
                    end else if (link_ack) begin
                        if (idx_r == LAST) begin
                            state_r <= SEQ_IDLE;
                            done_r <= 1'b1;
                        end else begin
                            idx_r <= IDX_W'(idx_r + 1'b1);
                        end
                    end
                end
                default: begin
                    state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign xf.valid = (state_r == SEQ_SEND);
    assign xf.index = idx_r;
    assign xf.done = done_r;
    assign xf.fail = fail_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    seq_start_idx_a: assert property (
        xf.start && state_r == SEQ_IDLE |=> xf.valid && idx_r == '0)
        else $error("transfer did not start at first register");
    seq_last_done_a: assert property (
        xf.valid && idx_r == LAST && link_ack && !link_fail |=> done_r && !xf.valid)
        else $error("last ack did not finish transfer");
    seq_fail_stop_a: assert property (
        xf.valid && link_fail |=> fail_r && !done_r && !xf.valid)
        else $error("radio failure did not abort transfer");
endmodule
`default_nettype wire

/* File: logic/link_register_sync_test_ctrl.sv */
// link register sync state, forced reconfiguration and radio test mode control
// assumes a slave port decoder (spi or two-wire) outside delivering register strobes,
// and a radio/control channel that acknowledges each offered register value
`include "link_sync_regs.svh"
`default_nettype none
module link_register_sync_test_ctrl
    import link_sync_pkg::*;
#(
    parameter int NREG = `LINK_REG_COUNT,
    parameter int IDX_W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register access from the slave port
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    output logic [7:0] acc_rdata_r,
    // role and link events
    input wire logic role_transmitter,
    input wire logic link_established,
    input wire logic force_reconfig,
    // control channel to the far end
    input wire logic link_ack,
    input wire logic link_fail,
    output logic xfer_valid_r,
    output logic [IDX_W-1:0] xfer_index_r,
    // results to the rest of the device
    output logic remote_done_flag_r,
    output logic reconfig_pulse_r,
    output logic test_mode_r,
    output logic test_sweep_r,
    output logic test_tx_r,
    output logic [6:0] test_channel_r,
    output logic power_0dbm_r
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0] sync_state_r; // visible sync status
    logic [7:0] pat_stage_r; // pattern as written, not yet live
    logic [7:0] ch_stage_r; // channel as written, not yet live
    logic start_r; // kick to the sequencer
    logic role_tx_r; // role sampled on every clock edge, in reset or not
    logic is_sync_wr; // write of the busy code to sync state
    logic code_ok; // staged pattern names a known test
    sync_xfer_if #(.IDX_W(IDX_W)) xf();

    assign xf.start = start_r;
    assign is_sync_wr = acc_wr && acc_addr == `OFS_LINK_SYNC_STATE && acc_wdata == `SYNC_BUSY;
    assign code_ok = pat_stage_r == `TEST_CODE_SINGLE || pat_stage_r == `TEST_CODE_SWEEP;

    // ****************************************
    // sequencer
    // ****************************************
    sync_sequencer #(.NREG(NREG), .IDX_W(IDX_W)) u_seq (
        .clk_sys(clk_sys),
        .srst(srst),
        .xf(xf),
        .link_ack(link_ack),
        .link_fail(link_fail)
    );

    // role strap held by a clocked process, never by reset itself
    always_ff @(posedge clk_sys) begin
        role_tx_r <= role_transmitter;
    end

    // sync state: busy on request, back to idle on result
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_state_r <= `SYNC_IDLE_OK;
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (xf.done) begin
                sync_state_r <= `SYNC_IDLE_OK;
            end else if (xf.fail) begin
                sync_state_r <= `SYNC_IDLE_FAIL;
            end else if (is_sync_wr && role_tx_r && sync_state_r != `SYNC_BUSY) begin
                // receivers and busy writes are ignored, state stays put
                sync_state_r <= `SYNC_BUSY;
                start_r <= 1'b1;
            end
            // other writes leave a failure showing until a fresh start
        end
    end

    // transfer outputs mirrored from the sequencer one cycle later
    // timing: start_r costs one edge, the sequencer state another and this mirror a third,
    // so the first offer shows three edges after the start write is taken; the offer drops
    // in the edge after each ack, so a fast peer spends two cycles per value
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            xfer_valid_r <= 1'b0;
            xfer_index_r <= '0;
            remote_done_flag_r <= 1'b0;
        end else begin
            xfer_valid_r <= xf.valid && !link_ack && !link_fail;
            xfer_index_r <= xf.valid && link_ack ? IDX_W'(xf.index + 1'b1) : xf.index;
            remote_done_flag_r <= xf.done;
        end
    end

    // staged test registers, write-only, from whichever slave port decoded
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pat_stage_r <= `TEST_REG_RESET;
            ch_stage_r <= `TEST_REG_RESET;
        end else if (acc_wr && !test_mode_r) begin
            // once in test mode, new settings wait for reset
            if (acc_addr == `OFS_TEST_PATTERN) begin
                pat_stage_r <= acc_wdata;
            end else if (acc_addr == `OFS_TEST_CHANNEL) begin
                ch_stage_r <= acc_wdata;
            end
        end
    end

    // reconfiguration: on every new link and on force request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reconfig_pulse_r <= 1'b0;
        end else begin
            reconfig_pulse_r <= link_established || force_reconfig;
        end
    end

    // test mode entry latches staged settings; only reset leaves
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            test_mode_r <= 1'b0;
            test_sweep_r <= 1'b0;
            test_tx_r <= 1'b0;
            test_channel_r <= '0;
            power_0dbm_r <= 1'b0;
        end else if (force_reconfig && code_ok && !test_mode_r) begin
            test_mode_r <= 1'b1;
            test_sweep_r <= pat_stage_r == `TEST_CODE_SWEEP;
            test_tx_r <= ch_stage_r[`TEST_DIR_BIT];
            test_channel_r <= ch_stage_r[`TEST_CH_MSB:0];
            power_0dbm_r <= 1'b1;
        end
    end

    // read port: test registers are write-only and read zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acc_rdata_r <= 8'h00;
        end else if (acc_rd && acc_addr == `OFS_LINK_SYNC_STATE) begin
            acc_rdata_r <= sync_state_r;
        end else if (acc_rd) begin
            acc_rdata_r <= 8'h00;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // busy shows one edge after the write, the offer two edges after that
    sync_start_busy_a: assert property (
        is_sync_wr && role_tx_r && sync_state_r != `SYNC_BUSY && !xf.done && !xf.fail
        |=> sync_state_r == `SYNC_BUSY ##2 xfer_valid_r)
        else $error("start write did not begin transfer");
    sync_done_clear_a: assert property (
        xf.done |=> sync_state_r == `SYNC_IDLE_OK && remote_done_flag_r)
        else $error("done did not clear state and raise flag");
    sync_busy_read_a: assert property (
        acc_rd && acc_addr == `OFS_LINK_SYNC_STATE && sync_state_r == `SYNC_BUSY
        |=> acc_rdata_r == `SYNC_BUSY)
        else $error("busy not reported on read");
    sync_fail_set_a: assert property (
        xf.fail |=> sync_state_r == `SYNC_IDLE_FAIL && !remote_done_flag_r)
        else $error("abort did not report failure");
    fail_hold_a: assert property (
        sync_state_r == `SYNC_IDLE_FAIL && !is_sync_wr |=> sync_state_r == `SYNC_IDLE_FAIL)
        else $error("failure value lost without new start");
    rx_role_ignore_a: assert property (
        !role_tx_r && sync_state_r == `SYNC_IDLE_OK |=> sync_state_r == `SYNC_IDLE_OK)
        else $error("receiver started a transfer");
    // the mirrored offer never outlives the sequencer's own offer
    offer_mirror_a: assert property (
        xfer_valid_r |-> xf.valid)
        else $error("offer shown with no transfer running");
    reconfig_event_a: assert property (
        link_established || force_reconfig |=> reconfig_pulse_r)
        else $error("link event without reconfiguration");
    test_sticky_a: assert property (
        test_mode_r |=> test_mode_r && power_0dbm_r && $stable(test_channel_r)
        && $stable(test_tx_r))
        else $error("test mode changed before reset");
    // staged settings frozen once the test runs
    test_late_write_a: assert property (
        test_mode_r && acc_wr |=> $stable(pat_stage_r) && $stable(ch_stage_r))
        else $error("test settings changed before reset");
    test_entry_a: assert property (
        force_reconfig && !test_mode_r && pat_stage_r == `TEST_CODE_SINGLE
        |=> test_mode_r && !test_sweep_r && test_channel_r == $past(ch_stage_r[6:0]))
        else $error("single channel test not entered");
    test_sweep_a: assert property (
        force_reconfig && !test_mode_r && pat_stage_r == `TEST_CODE_SWEEP
        |=> test_mode_r && test_sweep_r)
        else $error("sweep test not entered");
    test_dir_a: assert property (
        force_reconfig && code_ok && !test_mode_r
        |=> test_tx_r == $past(ch_stage_r[`TEST_DIR_BIT]))
        else $error("test direction not taken from channel byte");
    // unknown codes only reconfigure, they never start a test
    test_bad_code_a: assert property (
        force_reconfig && !code_ok && !test_mode_r |=> !test_mode_r)
        else $error("test mode entered on unknown code");
    test_power_a: assert property (
        power_0dbm_r == test_mode_r)
        else $error("power override out of step with test mode");
    // write-only registers must not leak staged values on reads
    test_reg_read_a: assert property (
        acc_rd && (acc_addr == `OFS_TEST_PATTERN || acc_addr == `OFS_TEST_CHANNEL)
        |=> acc_rdata_r == 8'h00)
        else $error("write-only register read back nonzero");
endmodule
`default_nettype wire

/* File: tb/radio_peer.sv */
// far end of the control channel: answers each offered link register value
// assumes offer and index come straight from the block's registered outputs
`default_nettype none
module radio_peer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // offer from the block
    input wire logic xfer_valid_r,
    input wire logic [3:0] xfer_index_r,
    // behaviour chosen by the bench
    input wire logic [1:0] delay,
    input wire logic fail_en,
    input wire logic [3:0] fail_idx,
    // answers
    output logic link_ack,
    output logic link_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_r; // cycles spent on the current offer
    logic answer; // answer this offer now
    // wait restarts per offer, so a slow peer stalls every value
    always_ff @(posedge clk_sys) begin
        if (srst || !xfer_valid_r || answer) begin
            wait_r <= 2'h0;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end
    assign answer = xfer_valid_r && (wait_r >= delay);
    // failure only where the bench asks for it, one index
    assign link_fail = answer && fail_en && (xfer_index_r == fail_idx);
    assign link_ack = answer && !link_fail;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the link sync and test control block
// assumes the radio peer model answers offers; bench acts as host
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NREG = 9;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic acc_wr = 1'b0;
    logic acc_rd = 1'b0;
    logic [7:0] acc_addr = 8'h00;
    logic [7:0] acc_wdata = 8'h00;
    logic role_transmitter = 1'b1;
    logic link_established = 1'b0;
    logic force_reconfig = 1'b0;
    logic [1:0] delay = 2'h0;
    logic fail_en = 1'b0;
    logic [3:0] fail_idx = 4'h0;
    logic link_ack, link_fail, xfer_valid_r, remote_done_flag_r, reconfig_pulse_r;
    logic test_mode_r, test_sweep_r, test_tx_r, power_0dbm_r;
    logic [7:0] acc_rdata_r, ack_cnt, done_cnt, got;
    logic [7:0] idx_bad; // acks whose index broke the order
    logic cnt_clr = 1'b0; // clears the counters below
    logic [3:0] xfer_index_r;
    logic [6:0] test_channel_r;
    int miscompares = 0;
    int num_checks = 0;
    // ****************************************
    // design and far end
    // ****************************************
    link_register_sync_test_ctrl #(.NREG(NREG), .IDX_W(4)) dut_u (.clk_sys(clk_sys),
        .srst(srst), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata_r(acc_rdata_r), .role_transmitter(role_transmitter),
        .link_established(link_established), .force_reconfig(force_reconfig),
        .link_ack(link_ack), .link_fail(link_fail), .xfer_valid_r(xfer_valid_r),
        .xfer_index_r(xfer_index_r), .remote_done_flag_r(remote_done_flag_r),
        .reconfig_pulse_r(reconfig_pulse_r), .test_mode_r(test_mode_r),
        .test_sweep_r(test_sweep_r), .test_tx_r(test_tx_r),
        .test_channel_r(test_channel_r), .power_0dbm_r(power_0dbm_r));
    radio_peer peer_u (.clk_sys(clk_sys), .srst(srst), .xfer_valid_r(xfer_valid_r),
        .xfer_index_r(xfer_index_r), .delay(delay), .fail_en(fail_en),
        .fail_idx(fail_idx), .link_ack(link_ack), .link_fail(link_fail));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // counts of accepted values and done pulses
    always @(posedge clk_sys) begin
        if (cnt_clr) begin
            ack_cnt <= 8'h00;
            done_cnt <= 8'h00;
            idx_bad <= 8'h00;
        end else begin
            if (link_ack) ack_cnt <= ack_cnt + 8'h01;
            // each ack must land on the next index, index 0 first
            if (link_ack && {4'h0, xfer_index_r} != ack_cnt) idx_bad <= idx_bad + 8'h01;
            if (remote_done_flag_r) done_cnt <= done_cnt + 8'h01;
        end
    end
    // ****************************************
    // host side tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic role);
        @(posedge clk_sys);
        srst <= 1'b1;
        role_transmitter <= role;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        acc_wr <= 1'b1;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge clk_sys);
        acc_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        acc_rd <= 1'b1;
        acc_addr <= a;
        @(posedge clk_sys);
        acc_rd <= 1'b0;
        #1;
        got = acc_rdata_r;
    endtask
    // poll the sync state until it leaves busy, bounded
    task automatic poll_idle();
        for (int i = 0; i < 100; i++) begin
            rd(8'h3E);
            if (got !== 8'h01) return;
        end
        chk("sync state wait", 8'h00, got);
        report_and_stop();
    endtask
    task automatic pulse(input bit force_it);
        @(posedge clk_sys);
        if (force_it) force_reconfig <= 1'b1;
        else link_established <= 1'b1;
        @(posedge clk_sys);
        force_reconfig <= 1'b0;
        link_established <= 1'b0;
        #1;
    endtask
    task automatic sync_run(input logic [1:0] d, input logic f, input logic [7:0] exp);
        @(posedge clk_sys);
        delay <= d;
        fail_en <= f;
        fail_idx <= 4'h3;
        cnt_clr <= 1'b1;
        @(posedge clk_sys);
        cnt_clr <= 1'b0;
        wr(8'h3E, 8'h01);
        rd(8'h3E);
        chk("sync busy", 8'h01, got);
        poll_idle();
        chk("sync result", exp, got);
        chk("acks", f ? 8'h03 : 8'(NREG), ack_cnt);
        chk("index order", 8'h00, idx_bad);
        chk("done flag", f ? 8'h00 : 8'h01, done_cnt);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        do_reset(1'b1);
        rd(8'h3E);
        chk("reset sync", 8'h00, got);
        rd(8'h7E);
        chk("write-only read", 8'h00, got);
        sync_run(2'h0, 1'b0, 8'h00);
        sync_run(2'h3, 1'b0, 8'h00);
        sync_run(2'h1, 1'b1, 8'h02);
        wr(8'h3E, 8'h00);
        rd(8'h3E);
        chk("fail kept", 8'h02, got);
        sync_run(2'h0, 1'b0, 8'h00);
        pulse(1'b0);
        chk("relink reconfig", 8'h01, 8'(reconfig_pulse_r));
        pulse(1'b1);
        chk("force reconfig", 8'h01, 8'(reconfig_pulse_r));
        chk("no test code", 8'h00, 8'(test_mode_r));
        wr(8'h7E, 8'h63);
        wr(8'h7F, 8'h85);
        pulse(1'b1);
        chk("test entry", 8'h01, 8'(test_mode_r));
        chk("single", 8'h00, 8'(test_sweep_r));
        chk("tx dir", 8'h01, 8'(test_tx_r));
        chk("channel", 8'h05, 8'(test_channel_r));
        chk("power", 8'h01, 8'(power_0dbm_r));
        wr(8'h7E, 8'h73);
        wr(8'h7F, 8'h05);
        pulse(1'b1);
        chk("sticky sweep", 8'h00, 8'(test_sweep_r));
        chk("sticky tx", 8'h01, 8'(test_tx_r));
        do_reset(1'b1);
        #1;
        chk("reset exit", 8'h00, 8'(test_mode_r));
        wr(8'h7E, 8'h73);
        wr(8'h7F, 8'h05);
        pulse(1'b1);
        chk("sweep", 8'h01, 8'(test_sweep_r));
        chk("rx dir", 8'h00, 8'(test_tx_r));
        do_reset(1'b0);
        wr(8'h3E, 8'h01);
        rd(8'h3E);
        chk("receiver sync", 8'h00, got);
        chk("receiver offer", 8'h00, 8'(xfer_valid_r));
        report_and_stop();
    end
endmodule
`default_nettype wire
